// ---- src/urgent_irq_pkg.sv ----
// Constants, register map and source tables for the urgent interrupt logic
package urgent_irq_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] OFF_PSW        = 8'h00;
    localparam logic [7:0] OFF_USAVED_PC  = 8'h04;
    localparam logic [7:0] OFF_USAVED_ST  = 8'h08;
    localparam logic [7:0] OFF_CAUSE      = 8'h0c;
    localparam logic [7:0] OFF_MSAVED_PC  = 8'h10;
    localparam logic [7:0] OFF_MSAVED_ST  = 8'h14;
    localparam logic [7:0] OFF_CONFIG     = 8'h18;
    localparam logic [7:0] OFF_STATUS     = 8'h1c;
    localparam logic [7:0] OFF_TRAP_PC    = 8'h20;

    // Status word fields
    localparam int unsigned PSW_NP = 7;
    localparam int unsigned PSW_EP = 6;
    localparam int unsigned PSW_ID = 5;
    localparam logic [31:0] PSW_RESET    = 32'h0000_0020;
    localparam logic [31:0] PSW_WR_MASK  = 32'h0000_00ff;

    // Configuration fields: pin edge, watchdog mode bit pairs
    localparam int unsigned CFG_EDGE_LO  = 0;
    localparam int unsigned CFG_W1_LO    = 2;
    localparam int unsigned CFG_W2_LO    = 4;
    localparam int unsigned CFG_W        = 6;
    localparam logic [5:0]  CFG_RESET    = 6'h00;
    localparam logic [1:0]  WDOG1_URGENT_MODE = 2'b10;
    localparam logic [1:0]  WDOG2_URGENT_MODE = 2'b01;

    // Cause codes and handler addresses
    localparam logic [15:0] PIN_CODE   = 16'h0010;
    localparam logic [15:0] WDOG1_CODE = 16'h0020;
    localparam logic [15:0] WDOG2_CODE = 16'h0030;
    localparam logic [15:0] TRAP_CODE  = 16'h0060;
    localparam logic [31:0] PIN_HANDLER   = 32'h0000_0010;
    localparam logic [31:0] WDOG1_HANDLER = 32'h0000_0020;
    localparam logic [31:0] WDOG2_HANDLER = 32'h0000_0030;
    localparam logic [31:0] TRAP_HANDLER  = 32'h0000_0060;
    localparam logic [31:0] ILLEGAL_PC_STEP = 32'h0000_0004;

    // Maskable sources, listed in default priority order
    localparam int unsigned MASK_N  = 12;
    localparam int unsigned LEVEL_W = 3;
    localparam logic [15:0] MASK_CODE [MASK_N] = '{
        16'h01e0, 16'h01f0, 16'h0210, 16'h0220, 16'h0230, 16'h0240,
        16'h0250, 16'h0260, 16'h0390, 16'h03a0, 16'h03b0, 16'h03c0};
    localparam logic [5:0]  MASK_DPRIO [MASK_N] = '{
        6'h16, 6'h17, 6'h19, 6'h1a, 6'h1b, 6'h1c,
        6'h1d, 6'h1e, 6'h2d, 6'h2e, 6'h2f, 6'h30};

    // Pin edge selection
    typedef enum logic [1:0] {
        EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH
    } edge_sel_t;

    // What urgent service is running
    typedef enum logic [1:0] {
        SVC_NONE, SVC_PIN, SVC_WDOG
    } svc_t;

endpackage

// ---- src/urgent_pin_edge.sv ----
// Synchroniser and selectable edge detector for the urgent pin
`timescale 1ns/1ps
`default_nettype none
module urgent_pin_edge
    import urgent_irq_pkg::*;
(
    // Clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    // Pin and edge selection
    input  wire logic      pin_i,
    input  wire edge_sel_t edge_sel_i,
    // One-cycle request
    output logic           pulse_o
);

    logic sync1_q, sync2_q, prev_q, pulse_q;
    logic pulse_d;

    // Edge decode on the second stage only, never the first
    always_comb begin
        case (edge_sel_i)
            EDGE_RISE: pulse_d = sync2_q & ~prev_q;
            EDGE_FALL: pulse_d = ~sync2_q & prev_q;
            EDGE_BOTH: pulse_d = sync2_q ^ prev_q;
            default:   pulse_d = 1'b0;
        endcase
    end

    // Two-stage synchroniser plus history flop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            pulse_q <= pulse_d;
        end
    end

    assign pulse_o = pulse_q;

endmodule
`default_nettype wire

// ---- src/urgent_irq_ctrl.sv ----
// Urgent interrupt entry, return and maskable vectoring for the core
// How it works
// (R1) Urgent requests ignore masking and beat all
// (R2) Simultaneous urgent: wdog2, wdog1, pin; drop rest
// (R3) Pin edge: rising, falling, both or off
// (R4) Wdog1 overflow urgent only when mode 10
// (R5) Wdog2 overflow urgent only when mode 01
// (R6) Pin request during pin service waits return
// (R7) Wdog1 during pin waits if flag set
// (R8) Wdog2 preempts pin service at once
// (R9) Entry saves restored PC then status
// (R10) Cause code into upper half, lower kept
// (R11) Entry sets in-service, block; clears trap
// (R12) PC loads fixed handler of chosen source
// (R13) Return with flags 0,1 restores urgent state
// (R14) Maskable handler equals its code zero-extended
// (R15) Same-level maskable ties go by default priority
// (R16) Restored PC: next, or restart aborted instruction
// (R17) Illegal opcode saved PC minus four is offender
// (R18) In-service flag blocks equal urgent requests
// (R19) Maskable waits until in-service and block clear
// (R20) Pin synchronised, one pulse per valid edge
// (R21) Pending latches clear on accept and reset
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module urgent_irq_ctrl
    import urgent_irq_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      reset_n_i,
    // Wishbone classic slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    // Request sources
    input  wire logic                      urgent_pin_i,
    input  wire logic                      wdog1_ovf_i,
    input  wire logic                      wdog2_ovf_i,
    input  wire logic [MASK_N-1:0]         mask_req_i,
    input  wire logic [MASK_N*LEVEL_W-1:0] mask_level_i,
    // Core pipeline
    input  wire logic                      boundary_i,
    input  wire logic                      restart_insn_i,
    input  wire logic [31:0]               current_pc_i,
    input  wire logic [31:0]               following_pc_i,
    input  wire logic                      illegal_op_i,
    input  wire logic                      return_i,
    output logic                           redirect_o,
    output logic      [31:0]               redirect_pc_o,
    output logic      [31:0]               psw_o
);

    // Reset release through two flops
    logic rst_sync1_q, rst_n;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync1_q <= 1'b0;
            rst_n       <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_n       <= rst_sync1_q;
        end
    end

    // Byte-lane merge for bus writes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // State
    logic [31:0]       psw_q, psw_d, usaved_pc_q, usaved_pc_d;
    logic [31:0]       usaved_st_q, usaved_st_d, cause_q, cause_d;
    logic [31:0]       msaved_pc_q, msaved_pc_d, msaved_st_q, msaved_st_d;
    logic [31:0]       trap_pc_q, trap_pc_d, rd_pc_q, rd_pc_d;
    logic [CFG_W-1:0]  cfg_q, cfg_d;
    logic              pend_pin_q, pend_pin_d, pend_w1_q, pend_w1_d;
    logic              pend_w2_q, pend_w2_d, redir_q, redir_d;
    logic [MASK_N-1:0] mpend_q, mpend_d;
    svc_t              svc_q, svc_d;
    logic              ack_q, ack_d;
    logic [31:0]       dat_q, dat_d;

    // Pin detector
    logic pin_pulse;
    urgent_pin_edge u_pin_edge (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n),
        .pin_i      (urgent_pin_i),
        .edge_sel_i (edge_sel_t'(cfg_q[CFG_EDGE_LO +: 2])), // [R3] [R20]
        .pulse_o    (pin_pulse)
    );

    // Source qualification and same-cycle discard
    logic w1_evt, w2_evt, set_pin, set_w1, set_w2;
    assign w1_evt  = wdog1_ovf_i &
                     (cfg_q[CFG_W1_LO +: 2] == WDOG1_URGENT_MODE); // [R4]
    assign w2_evt  = wdog2_ovf_i &
                     (cfg_q[CFG_W2_LO +: 2] == WDOG2_URGENT_MODE); // [R5]
    assign set_w2  = w2_evt;                                        // [R2]
    assign set_w1  = w1_evt & ~w2_evt;                              // [R2]
    assign set_pin = pin_pulse & ~w1_evt & ~w2_evt;                 // [R2]

    // Maskable pick: lowest level, ties by default priority number
    logic [3:0] mpick;
    logic       many;
    always_comb begin
        logic [LEVEL_W-1:0] best;
        best  = '1;
        mpick = 4'h0;
        many  = 1'b0;
        for (int i = 0; i < MASK_N; i++) begin
            if (mpend_q[i]) begin
                if (!many ||
                    mask_level_i[i*LEVEL_W +: LEVEL_W] < best ||
                    (mask_level_i[i*LEVEL_W +: LEVEL_W] == best &&
                     MASK_DPRIO[i] < MASK_DPRIO[mpick])) begin // [R15]
                    best  = mask_level_i[i*LEVEL_W +: LEVEL_W];
                    mpick = 4'(i);
                end
                many = 1'b1;
            end
        end
    end

    // Acceptance decisions
    logic np, id, ep, take_w2, take_w1, take_pin, take_urg;
    logic take_trap, take_mask, bus_wr;
    logic [31:0] restored_pc;
    assign np = psw_q[PSW_NP];
    assign id = psw_q[PSW_ID];
    assign ep = psw_q[PSW_EP];
    // Interrupt block flag is not consulted for urgent sources
    assign take_w2  = boundary_i & ~return_i & pend_w2_q &
                      (~np | (svc_q == SVC_PIN));             // [R1] [R8] [R18]
    assign take_w1  = boundary_i & ~return_i & ~take_w2 &
                      pend_w1_q & ~np;                        // [R7] [R18]
    assign take_pin = boundary_i & ~return_i & ~take_w2 & ~take_w1 &
                      pend_pin_q & ~np & (svc_q != SVC_PIN);  // [R6] [R18]
    assign take_urg = take_w2 | take_w1 | take_pin;
    assign take_trap = illegal_op_i & ~return_i & ~take_urg;
    assign take_mask = boundary_i & ~return_i & ~take_urg & ~take_trap &
                       many & ~np & ~id;                      // [R1] [R19]
    assign restored_pc = restart_insn_i ? current_pc_i
                                        : following_pc_i;     // [R16]
    assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

    // Next state of the entry and return sequencer
    always_comb begin
        psw_d       = psw_q;
        usaved_pc_d = usaved_pc_q;
        usaved_st_d = usaved_st_q;
        cause_d     = cause_q;
        msaved_pc_d = msaved_pc_q;
        msaved_st_d = msaved_st_q;
        trap_pc_d   = trap_pc_q;
        cfg_d       = cfg_q;
        svc_d       = svc_q;
        redir_d     = 1'b0;
        rd_pc_d     = rd_pc_q;
        // Set beats clear so a request in the accept cycle survives
        pend_w2_d   = set_w2  | (pend_w2_q  & ~take_w2);      // [R21]
        pend_w1_d   = set_w1  | (pend_w1_q  & ~take_w1);      // [R21]
        pend_pin_d  = set_pin | (pend_pin_q & ~take_pin);     // [R21]
        mpend_d     = mask_req_i | mpend_q;
        if (take_mask) begin
            mpend_d[mpick] = mask_req_i[mpick];
        end
        // Software writes first; hardware events below override
        if (bus_wr) begin
            case (wb_adr_i)
                OFF_PSW:       psw_d = merge(psw_q, wb_dat_i, wb_sel_i) &
                                       PSW_WR_MASK;
                OFF_USAVED_PC: usaved_pc_d = merge(usaved_pc_q, wb_dat_i,
                                                   wb_sel_i);
                OFF_USAVED_ST: usaved_st_d = merge(usaved_st_q, wb_dat_i,
                                                   wb_sel_i);
                OFF_CAUSE:     cause_d = merge(cause_q, wb_dat_i, wb_sel_i);
                OFF_MSAVED_PC: msaved_pc_d = merge(msaved_pc_q, wb_dat_i,
                                                   wb_sel_i);
                OFF_MSAVED_ST: msaved_st_d = merge(msaved_st_q, wb_dat_i,
                                                   wb_sel_i);
                OFF_CONFIG:    if (wb_sel_i[0]) begin
                    cfg_d = wb_dat_i[CFG_W-1:0];
                end
                default: ;
            endcase
        end
        if (take_urg) begin
            usaved_pc_d = restored_pc;                        // [R9]
            usaved_st_d = psw_q;                              // [R9]
            psw_d[PSW_NP] = 1'b1;                             // [R11]
            psw_d[PSW_ID] = 1'b1;                             // [R11]
            psw_d[PSW_EP] = 1'b0;                             // [R11]
            redir_d = 1'b1;
            svc_d   = take_pin ? SVC_PIN : SVC_WDOG;
            if (take_w2) begin
                cause_d[31:16] = WDOG2_CODE;                  // [R10]
                rd_pc_d        = WDOG2_HANDLER;               // [R12]
            end else if (take_w1) begin
                cause_d[31:16] = WDOG1_CODE;                  // [R10]
                rd_pc_d        = WDOG1_HANDLER;               // [R12]
            end else begin
                cause_d[31:16] = PIN_CODE;                    // [R10]
                rd_pc_d        = PIN_HANDLER;                 // [R12]
            end
        end else if (take_trap) begin
            // Offending address is recovered as saved value minus four
            trap_pc_d      = current_pc_i + ILLEGAL_PC_STEP;  // [R17]
            cause_d[15:0]  = TRAP_CODE;
            psw_d[PSW_EP]  = 1'b1;
            psw_d[PSW_ID]  = 1'b1;
            redir_d        = 1'b1;
            rd_pc_d        = TRAP_HANDLER;
        end else if (take_mask) begin
            msaved_pc_d    = restored_pc;                     // [R16]
            msaved_st_d    = psw_q;
            cause_d[15:0]  = MASK_CODE[mpick];
            psw_d[PSW_ID]  = 1'b1;
            psw_d[PSW_EP]  = 1'b0;
            redir_d        = 1'b1;
            rd_pc_d        = {16'h0000, MASK_CODE[mpick]};    // [R14]
        end else if (return_i) begin
            redir_d = 1'b1;
            if (ep) begin
                rd_pc_d       = trap_pc_q;
                psw_d[PSW_EP] = 1'b0;
            end else if (np) begin
                rd_pc_d = usaved_pc_q;                        // [R13]
                psw_d   = usaved_st_q;                        // [R13]
                svc_d   = SVC_NONE;                           // [R6]
            end else begin
                rd_pc_d = msaved_pc_q;
                psw_d   = msaved_st_q;
            end
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            psw_q       <= PSW_RESET;
            usaved_pc_q <= '0;
            usaved_st_q <= '0;
            cause_q     <= '0;
            msaved_pc_q <= '0;
            msaved_st_q <= '0;
            trap_pc_q   <= '0;
            cfg_q       <= CFG_RESET;
            svc_q       <= SVC_NONE;
            pend_pin_q  <= 1'b0;                              // [R21]
            pend_w1_q   <= 1'b0;
            pend_w2_q   <= 1'b0;
            mpend_q     <= '0;
            redir_q     <= 1'b0;
            rd_pc_q     <= '0;
        end else begin
            psw_q       <= psw_d;
            usaved_pc_q <= usaved_pc_d;
            usaved_st_q <= usaved_st_d;
            cause_q     <= cause_d;
            msaved_pc_q <= msaved_pc_d;
            msaved_st_q <= msaved_st_d;
            trap_pc_q   <= trap_pc_d;
            cfg_q       <= cfg_d;
            svc_q       <= svc_d;
            pend_pin_q  <= pend_pin_d;
            pend_w1_q   <= pend_w1_d;
            pend_w2_q   <= pend_w2_d;
            mpend_q     <= mpend_d;
            redir_q     <= redir_d;
            rd_pc_q     <= rd_pc_d;
        end
    end

    // Bus answer: ack one cycle after request, read data held with it
    always_comb begin
        ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
        dat_d = dat_q;
        if (ack_d) begin
            case (wb_adr_i)
                OFF_PSW:       dat_d = psw_q;
                OFF_USAVED_PC: dat_d = usaved_pc_q;
                OFF_USAVED_ST: dat_d = usaved_st_q;
                OFF_CAUSE:     dat_d = cause_q;
                OFF_MSAVED_PC: dat_d = msaved_pc_q;
                OFF_MSAVED_ST: dat_d = msaved_st_q;
                OFF_CONFIG:    dat_d = {26'h0, cfg_q};
                OFF_STATUS:    dat_d = {15'h0, mpend_q, svc_q,
                                        pend_w2_q, pend_w1_q, pend_pin_q};
                OFF_TRAP_PC:   dat_d = trap_pc_q;
                default:       dat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o      = ack_q;
    assign wb_dat_o      = dat_q;
    assign redirect_o    = redir_q;
    assign redirect_pc_o = rd_pc_q;
    assign psw_o         = psw_q;

    // Checks on the sequencer
    AST_W2_PREEMPTS: assert property (@(posedge clk_i) disable iff (!rst_n)
        svc_q == SVC_PIN && pend_w2_q && boundary_i && !return_i
        |=> redirect_o && redirect_pc_o == WDOG2_HANDLER) // [R8]
        else $error("wdog2 did not preempt pin service");
    AST_PIN_HELD: assert property (@(posedge clk_i) disable iff (!rst_n)
        svc_q == SVC_PIN && !return_i
        |=> !(redirect_o && redirect_pc_o == PIN_HANDLER)) // [R6]
        else $error("pin request nested into pin service");
    AST_W1_HELD: assert property (@(posedge clk_i) disable iff (!rst_n)
        np && svc_q == SVC_PIN && !pend_w2_q
        |=> !(redirect_o && redirect_pc_o == WDOG1_HANDLER)) // [R7]
        else $error("wdog1 taken while in-service flag set");
    AST_PRIORITY: assert property (@(posedge clk_i) disable iff (!rst_n)
        pend_w2_q && pend_w1_q && boundary_i && !np && !return_i
        |=> redirect_pc_o == WDOG2_HANDLER && pend_w1_q) // [R2]
        else $error("urgent priority order broken");
    AST_ENTRY: assert property (@(posedge clk_i) disable iff (!rst_n)
        take_urg |=> psw_q[PSW_NP] && psw_q[PSW_ID] && !psw_q[PSW_EP]
        && usaved_pc_q == $past(restored_pc)
        && usaved_st_q == $past(psw_q)) // [R9] [R11]
        else $error("urgent entry state wrong");
    AST_CAUSE: assert property (@(posedge clk_i) disable iff (!rst_n)
        take_w1 |=> cause_q[31:16] == WDOG1_CODE
        && cause_q[15:0] == $past(cause_q[15:0])) // [R10]
        else $error("cause half written wrongly");
    AST_W1_MODE: assert property (@(posedge clk_i) disable iff (!rst_n)
        !pend_w1_q && cfg_q[CFG_W1_LO +: 2] != WDOG1_URGENT_MODE
        |=> !pend_w1_q) // [R4]
        else $error("wdog1 latched outside urgent mode");
    AST_RETURN: assert property (@(posedge clk_i) disable iff (!rst_n)
        return_i && !ep && np |=> redirect_o
        && redirect_pc_o == $past(usaved_pc_q)
        && psw_q == $past(usaved_st_q)) // [R13]
        else $error("urgent return did not restore");
    AST_MASK_HELD: assert property (@(posedge clk_i) disable iff (!rst_n)
        (np || id) && !return_i && !bus_wr
        |=> $stable(msaved_pc_q)) // [R19]
        else $error("maskable taken while blocked");
    AST_ILLEGAL: assert property (@(posedge clk_i) disable iff (!rst_n)
        take_trap |=> trap_pc_q - ILLEGAL_PC_STEP
        == $past(current_pc_i)) // [R17]
        else $error("illegal opcode saved pc wrong");
    AST_PIN_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n)
        take_pin && !set_pin |=> !pend_pin_q ##1 1'b1) // [R21]
        else $error("pin pending not cleared on accept");

endmodule
`default_nettype wire

// ---- verification/core_model.sv ----
// Behavioural core pipeline that answers the urgent interrupt logic
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Bench command
    input  wire logic        ret_cmd_i,
    // Interrupt logic side
    input  wire logic        redirect_i,
    input  wire logic [31:0] target_i,
    output logic             boundary_o,
    output logic             return_o,
    output logic [31:0]      pc_o,
    output logic [31:0]      next_pc_o
);
    logic [31:0] pc_d;
    logic        ret_d;
    // Sits on one instruction so the saved PC is easy to predict
    always_comb begin
        pc_d  = redirect_i ? target_i : pc_o;
        ret_d = ret_cmd_i;
    end
    // State registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pc_o     <= 32'h0000_1000;
            return_o <= 1'b0;
        end else begin
            pc_o     <= pc_d;
            return_o <= ret_d;
        end
    end
    // No boundary while a jump lands; return is one pulse
    assign boundary_o = ~redirect_i;
    assign next_pc_o  = pc_o + 32'h0000_0004;
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the urgent interrupt logic
`timescale 1ns/1ps
`default_nettype none
module tb_top import urgent_irq_pkg::*; ;
    typedef struct packed {
        logic [5:0]  cfg;
        logic        pin;
        logic        w1;
        logic        w2;
        logic        hit;
        logic [31:0] pc;
    } row_t;
    // Edge modes, watchdog modes, then a simultaneous pair
    row_t rows [9] = '{
        '{6'h01, 1'b1, 1'b0, 1'b0, 1'b1, PIN_HANDLER},
        '{6'h02, 1'b0, 1'b0, 1'b0, 1'b1, PIN_HANDLER},
        '{6'h03, 1'b1, 1'b0, 1'b0, 1'b1, PIN_HANDLER},
        '{6'h00, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0},
        '{6'h08, 1'b0, 1'b1, 1'b0, 1'b1, WDOG1_HANDLER},
        '{6'h04, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0},
        '{6'h10, 1'b0, 1'b0, 1'b1, 1'b1, WDOG2_HANDLER},
        '{6'h20, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0},
        '{6'h18, 1'b0, 1'b1, 1'b1, 1'b1, WDOG2_HANDLER}};
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic        urgent_pin_i = 1'b0;
    logic        wdog1_ovf_i = 1'b0;
    logic        wdog2_ovf_i = 1'b0;
    logic [11:0] mask_req_i = 12'h000;
    logic        ret_cmd = 1'b0;
    logic [15:0] clo = 16'h0;
    logic [31:0] wb_dat_o, redirect_pc_o, psw_o, nxt, cur, sp, q;
    logic        wb_ack_o, redirect_o, boundary, ret, h;
    int          checked = 0;
    int          n_mismatch = 0;
    int          cyc = 0;
    always #12.5 clk_i = ~clk_i;
    // Select bits and level fields held constant
    urgent_irq_ctrl dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .urgent_pin_i(urgent_pin_i), .wdog1_ovf_i(wdog1_ovf_i),
        .wdog2_ovf_i(wdog2_ovf_i), .mask_req_i(mask_req_i),
        .mask_level_i(36'h0), .boundary_i(boundary), .restart_insn_i(1'b0),
        .current_pc_i(cur), .following_pc_i(nxt), .illegal_op_i(1'b0),
        .return_i(ret), .redirect_o(redirect_o),
        .redirect_pc_o(redirect_pc_o), .psw_o(psw_o));
    core_model core (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .ret_cmd_i(ret_cmd), .redirect_i(redirect_o),
        .target_i(redirect_pc_o), .boundary_o(boundary), .return_o(ret),
        .pc_o(cur), .next_pc_o(nxt));
    task automatic final_report;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Single cycle; waits on ack, no cap
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic redir(input int lim, output logic hit);
        hit = 1'b0;
        for (int n = 0; n < lim && !hit; n++) begin
            @(posedge clk_i);
            hit = (redirect_o === 1'b1);
        end
    endtask
    task automatic entry(input logic [31:0] pc, sp_e, st);
        redir(8, h);
        chk("target", redirect_pc_o, pc);
        chk("flags", psw_o & 32'he0, 32'ha0);
        wb(1'b0, OFF_CAUSE, 32'h0, q);
        chk("cause", q, {pc[15:0], clo});
        wb(1'b0, OFF_USAVED_PC, 32'h0, q);
        chk("saved pc", q, sp_e);
        wb(1'b0, OFF_USAVED_ST, 32'h0, q);
        chk("saved status", q, st);
    endtask
    task automatic leave(input logic [31:0] sp_e, st);
        ret_cmd <= 1'b1;
        @(posedge clk_i);
        ret_cmd <= 1'b0;
        redir(8, h);
        chk("return pc", redirect_pc_o, sp_e);
        chk("return psw", psw_o, st);
    endtask
    // Hang guard, well above the run length
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("psw reset", psw_o, PSW_RESET);
        chk("idle redirect", {31'h0, redirect_o}, 32'h0);
        $display("reset test done");
        // Two same-level maskable requests, held by the block flag
        mask_req_i <= 12'h101;
        @(posedge clk_i);
        mask_req_i <= 12'h000;
        redir(8, h);
        chk("blocked", {31'h0, h}, 32'h0);
        sp = nxt;
        wb(1'b1, OFF_PSW, 32'h0, q);
        redir(8, h);
        chk("mask pc", redirect_pc_o, {16'h0, MASK_CODE[0]});
        leave(sp, 32'h0);
        redir(8, h);
        chk("mask pc2", redirect_pc_o, {16'h0, MASK_CODE[8]});
        leave(sp + 32'h4, 32'h0);
        clo = MASK_CODE[8];
        $display("maskable test done");
        foreach (rows[i]) begin
            wb(1'b1, OFF_CONFIG, {26'h0, rows[i].cfg}, q);
            sp = nxt;
            urgent_pin_i <= rows[i].pin;
            wdog1_ovf_i  <= rows[i].w1;
            wdog2_ovf_i  <= rows[i].w2;
            @(posedge clk_i);
            wdog1_ovf_i <= 1'b0;
            wdog2_ovf_i <= 1'b0;
            if (rows[i].hit) begin
                entry(rows[i].pc, sp, 32'h0);
                leave(sp, 32'h0);
            end else begin
                redir(8, h);
                chk("no entry", {31'h0, h}, 32'h0);
            end
            wb(1'b0, OFF_STATUS, 32'h0, q);
            chk("pending", q & 32'h7, 32'h0);
            $display("row %0d done", i);
        end
        // Nesting during pin service
        wb(1'b1, OFF_CONFIG, 32'h19, q);
        sp = nxt;
        urgent_pin_i <= 1'b1;
        entry(PIN_HANDLER, sp, 32'h0);
        urgent_pin_i <= 1'b0;
        @(posedge clk_i);
        urgent_pin_i <= 1'b1;
        redir(8, h);
        chk("pin held", {31'h0, h}, 32'h0);
        sp = nxt;
        wdog2_ovf_i <= 1'b1;
        @(posedge clk_i);
        wdog2_ovf_i <= 1'b0;
        entry(WDOG2_HANDLER, sp, 32'ha0);
        leave(sp, 32'ha0);
        wb(1'b1, OFF_PSW, 32'h20, q);
        sp = nxt;
        entry(PIN_HANDLER, sp, 32'h20);
        sp = nxt;
        wdog1_ovf_i <= 1'b1;
        @(posedge clk_i);
        wdog1_ovf_i <= 1'b0;
        redir(8, h);
        chk("w1 held", {31'h0, h}, 32'h0);
        wb(1'b1, OFF_PSW, 32'h20, q);
        entry(WDOG1_HANDLER, sp, 32'h20);
        $display("nesting test done");
        final_report();
    end
endmodule
`default_nettype wire
